// ===== design/gpp_port_bank.sv
// programmable port bank: data latches, directions, pull-ups, filter
//
// Contract
// R1: port 0-3 pull-up bits act only on inputs; never in expansion modes.
// R2: second pull-up register groups ports 4-7; ports 4,5 off in expansion modes.
// R3: bit 6 pulls only port 7 pins 2,3; pins 0,1 never pulled.
// R4: third pull-up register groups ports 8,9,10 as mapped.
// R5: port 8 pin 5 never pulled up.
// R6: fourth register bits 6-0 pull ports 11-14 groups, inputs only.
// R7: fourth register bit 7 enables ports 11-14 data and direction.
// R8: upper ports disabled keep contents; reads give undefined data.
// R9: port 1 readback bit makes port 1 reads return the latch.
// R10: input bits read pin level; writes update latch only.
// R11: output bits read latch; latch drives pin.
// R12: expansion modes ignore writes to bus control pin bits.
// R13: open-drain pins float when latch holds one.
// R14: subclock on with port 8 pins 6,7 input gives undefined reads.
// R15: direction bit zero is input, one is output.
// R16: port 9 direction writable only in the write after unlock.
// R17: software changes filter only with nmi and motor timer bits clear; filter select writes are taken at any time.
// R18: nmi interrupt enable cannot be cleared once set.
// R19: hard reset loads second pull-up register from boot mode pin.
// R20: soft resets load second pull-up register from processor mode.
// R21: directions reset to zero, port 14 and filter select low bits zero.
// R22: nmi filter passes a level after three equal samples.
// R23: pin inputs pass two flip-flops before being read.
`timescale 1ns/100ps
module gpp_port_bank #(
	parameter int NPORT = gpp_pkg::NPORT
) (
	input  wire logic                 ref_clk,
	input  wire logic                 nrst,
	input  wire logic                 soft_rst,
	input  wire logic                 boot_mode_pin,
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [11:0]          wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic      [31:0]          wb_dat_o,
	output logic                      wb_ack_o,
	input  wire logic [NPORT*8-1:0]   pin_in,
	input  wire logic [NPORT*8-1:0]   bus_pin_mask,
	input  wire logic                 nmi_pin,
	output gpp_pkg::gpp_pins_type     pins_o,
	output logic                      nmi_filtered
);

	localparam int NP = NPORT * 8;

	// the register map is fixed; any other port count is refused
	if (NPORT != gpp_pkg::NPORT) begin : g_bad_nport
		$error("port count must match the register map");
	end

	// -----------------------------------------------------------------
	// reset release
	// -----------------------------------------------------------------
	logic rst_meta_q;
	logic rst_n_q;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	// -----------------------------------------------------------------
	// register state
	// -----------------------------------------------------------------
	logic [7:0]             pull0_q, pull1_q, pull2_q, pull3_q;
	logic [7:0]             port_ctl_q;
	logic [7:0]             filt_sel_q;
	logic [1:0]             mode_q;
	logic                   nmi_en_q, subclk_q, motor_func_q, motor_out_q;
	logic                   unlock_q;
	logic                   strap_done_q;
	logic [NPORT-1:0][7:0]  data_q;
	logic [NPORT-1:0][7:0]  dir_q;
	logic [NP-1:0]          pin_meta_q, pin_sync_q;
	logic                   ack_q;
	logic [31:0]            dat_q;
	logic [7:0]             rd_d;

	wire logic [9:0] idx      = wb_adr_i[11:2];
	wire logic       req      = wb_cyc_i & wb_stb_i & ~ack_q;
	wire logic       wr       = req & wb_we_i & wb_sel_i[0];
	wire logic [7:0] wdat     = wb_dat_i[7:0];
	wire logic       exp_mode = (mode_q != gpp_pkg::MODE_SINGLE);
	wire logic       upper_en = pull3_q[gpp_pkg::UPPER_PORTS_ENABLE_BIT];

	// -----------------------------------------------------------------
	// wishbone handshake: ack one cycle after a request, one cycle wide
	// -----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0;
		end else begin
			ack_q <= req;
			dat_q <= req ? {24'h0, rd_d} : dat_q;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	// -----------------------------------------------------------------
	// input synchronisers
	// -----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
		end else begin
			pin_meta_q <= pin_in; // R23
			pin_sync_q <= pin_meta_q; // R23
		end
	end

	// -----------------------------------------------------------------
	// pull-up and control registers
	// -----------------------------------------------------------------
	// the boot level is caught on the first clock after release, never under reset
	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pull0_q      <= gpp_pkg::RST_ZERO; // R21
			pull1_q      <= gpp_pkg::RST_ZERO;
			pull2_q      <= gpp_pkg::RST_ZERO;
			pull3_q      <= gpp_pkg::RST_ZERO;
			port_ctl_q   <= gpp_pkg::RST_ZERO;
			filt_sel_q   <= gpp_pkg::RST_ZERO; // R21
			strap_done_q <= 1'b0;
		end else if (!strap_done_q) begin
			strap_done_q <= 1'b1;
			pull1_q      <= boot_mode_pin ? gpp_pkg::RST_PULL1_HIGH : gpp_pkg::RST_ZERO; // R19
		end else if (soft_rst) begin
			pull0_q    <= gpp_pkg::RST_ZERO;
			pull1_q    <= exp_mode ? gpp_pkg::RST_PULL1_HIGH : gpp_pkg::RST_ZERO; // R20
			pull2_q    <= gpp_pkg::RST_ZERO;
			pull3_q    <= gpp_pkg::RST_ZERO;
			port_ctl_q <= gpp_pkg::RST_ZERO;
			filt_sel_q <= gpp_pkg::RST_ZERO;
		end else if (wr) begin
			if (idx == gpp_pkg::IDX_PULLUP_CTRL_0)
				pull0_q <= wdat;
			if (idx == gpp_pkg::IDX_PULLUP_CTRL_1)
				pull1_q <= wdat;
			if (idx == gpp_pkg::IDX_PULLUP_CTRL_2)
				pull2_q <= wdat;
			if (idx == gpp_pkg::IDX_PULLUP_CTRL_3)
				pull3_q <= wdat; // R7
			if (idx == gpp_pkg::IDX_PORT_CONTROL)
				port_ctl_q <= wdat & gpp_pkg::PORT_CTL_MASK;
			if (idx == gpp_pkg::IDX_NMI_FILTER)
				filt_sel_q <= wdat & gpp_pkg::NMI_FILT_MASK;
		end
	end

	// system control: processor mode, nmi enable, clock and motor timer flags
	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			mode_q       <= gpp_pkg::MODE_SINGLE;
			nmi_en_q     <= 1'b0;
			subclk_q     <= 1'b0;
			motor_func_q <= 1'b0;
			motor_out_q  <= 1'b0;
		end else if (wr && idx == gpp_pkg::IDX_SYS_CTRL) begin
			mode_q       <= wdat[gpp_pkg::SYS_MODE_LSB +: 2];
			nmi_en_q     <= nmi_en_q | wdat[gpp_pkg::SYS_NMI_EN_BIT]; // R18
			subclk_q     <= wdat[gpp_pkg::SYS_SUBCLK_BIT];
			motor_func_q <= wdat[gpp_pkg::SYS_MOTOR_FUNC_BIT];
			motor_out_q  <= wdat[gpp_pkg::SYS_MOTOR_OUT_BIT];
		end
	end

	// unlock lasts exactly until the next bus write, whatever it targets
	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q)
			unlock_q <= 1'b0;
		else if (wr)
			unlock_q <= (idx == gpp_pkg::IDX_SYS_CTRL) & wdat[gpp_pkg::SYS_UNLOCK_BIT]; // R16
	end

	// -----------------------------------------------------------------
	// port data latches and direction registers
	// -----------------------------------------------------------------
	for (genvar p = 0; p < NPORT; p++) begin : g_port
		localparam logic [7:0] PMASK = (p == NPORT - 1) ? gpp_pkg::PORT14_MASK : 8'hff;
		localparam bit UPPER = (p >= gpp_pkg::UPPER_PORT_FIRST);
		wire logic       port_ok = !UPPER || upper_en; // R8
		wire logic [7:0] wmask   = exp_mode ? ~bus_pin_mask[p*8 +: 8] : 8'hff; // R12
		wire logic       dir_ok  = (p != gpp_pkg::DIR9_PORT) || unlock_q; // R16

		always_ff @(posedge ref_clk or negedge rst_n_q) begin
			if (!rst_n_q)
				data_q[p] <= gpp_pkg::RST_ZERO;
			else if (wr && port_ok && idx == gpp_pkg::DATA_IDX[p])
				data_q[p] <= ((wdat & wmask) | (data_q[p] & ~wmask)) & PMASK; // R10
		end

		always_ff @(posedge ref_clk or negedge rst_n_q) begin
			if (!rst_n_q)
				dir_q[p] <= gpp_pkg::RST_ZERO; // R21
			else if (soft_rst && strap_done_q)
				dir_q[p] <= gpp_pkg::RST_ZERO; // R21
			else if (wr && port_ok && dir_ok && idx == gpp_pkg::DIR_IDX[p])
				dir_q[p] <= ((wdat & wmask) | (dir_q[p] & ~wmask)) & PMASK; // R15
		end
	end

	// -----------------------------------------------------------------
	// pin drive and pull-up mapping
	// -----------------------------------------------------------------
	// returns the bit of the four pull-up registers that pulls pin b of port p, or -1
	function automatic int pu_src(input int p, input int b);
		int r;
		r = -1;
		if (p <= 7)
			r = p * 2 + b / 4; // R1 R2
		if (p == 7 && b < 2)
			r = -1; // R3
		if (p == 8)
			r = (b < 4) ? 16 : ((b == 5) ? -1 : 17); // R4 R5
		if (p == 9 || p == 10)
			r = 18 + (p - 9) * 2 + b / 4; // R4
		if (p >= 11)
			r = 24 + (p - 11) * 2 + b / 4; // R6
		if (p == 14 && b >= 2)
			r = -1;
		return r;
	endfunction

	gpp_pkg::gpp_pins_type pins_d;
	wire logic [31:0] pur_all = {pull3_q, pull2_q, pull1_q, pull0_q};

	for (genvar i = 0; i < NP; i++) begin : g_pin
		localparam int SRC  = pu_src(i / 8, i % 8);
		localparam bit OD   = gpp_pkg::OPEN_DRAIN_MASK[i];
		localparam bit LOWP = (i < 48);
		localparam bit REAL = !(i / 8 == 14 && i % 8 >= 2);
		wire logic latch = data_q[i / 8][i % 8];
		wire logic dir   = dir_q[i / 8][i % 8];
		if (SRC < 0) begin : g_nopu
			assign pins_d.pu[i] = 1'b0; // R3 R5
		end else begin : g_pu
			assign pins_d.pu[i] = pur_all[SRC] & ~dir & ~(LOWP && exp_mode); // R1 R2 R6
		end
		if (OD) begin : g_od
			assign pins_d.out[i] = 1'b0;
			assign pins_d.oe[i]  = dir & ~latch; // R13
		end else begin : g_cmos
			assign pins_d.out[i] = latch & REAL; // R11
			assign pins_d.oe[i]  = dir & REAL; // R11 R15
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q)
			pins_o <= '0;
		else
			pins_o <= pins_d;
	end

	// -----------------------------------------------------------------
	// read multiplexer
	// -----------------------------------------------------------------
	always_comb begin
		logic [7:0] live;
		rd_d = 8'h00;
		live = 8'h00;
		for (int p = 0; p < NPORT; p++) begin
			live = (dir_q[p] & data_q[p]) | (~dir_q[p] & pin_sync_q[p*8 +: 8]); // R10 R11
			if (p == 1 && port_ctl_q[gpp_pkg::PORT1_LATCH_READBACK_BIT])
				live = data_q[p]; // R9
			if (p == 8 && subclk_q)
				live = live & ~(~dir_q[p] & 8'hc0); // R14
			if (p == NPORT - 1)
				live = live & gpp_pkg::PORT14_MASK;
			if (idx == gpp_pkg::DATA_IDX[p])
				rd_d = (p >= gpp_pkg::UPPER_PORT_FIRST && !upper_en) ? 8'h00 : live; // R8
			if (idx == gpp_pkg::DIR_IDX[p])
				rd_d = (p >= gpp_pkg::UPPER_PORT_FIRST && !upper_en) ? 8'h00 : dir_q[p]; // R8
		end
		unique case (idx)
			gpp_pkg::IDX_PULLUP_CTRL_0: rd_d = pull0_q;
			gpp_pkg::IDX_PULLUP_CTRL_1: rd_d = pull1_q;
			gpp_pkg::IDX_PULLUP_CTRL_2: rd_d = pull2_q;
			gpp_pkg::IDX_PULLUP_CTRL_3: rd_d = pull3_q;
			gpp_pkg::IDX_PORT_CONTROL:  rd_d = port_ctl_q;
			gpp_pkg::IDX_NMI_FILTER:    rd_d = filt_sel_q;
			gpp_pkg::IDX_SYS_CTRL:      rd_d = {nmi_filtered, unlock_q, motor_out_q,
				motor_func_q, subclk_q, nmi_en_q, mode_q};
			default: ;
		endcase
	end

	// -----------------------------------------------------------------
	// nmi input filter
	// -----------------------------------------------------------------
	// sample period is 2^select cycles; select 0 samples every cycle
	logic       nmi_meta_q, nmi_sync_q;
	logic [6:0] pre_q;
	logic [2:0] samp_q;
	wire logic  tick = ((pre_q & 7'((8'h1 << filt_sel_q[2:0]) - 8'h1)) == 7'h0);

	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			nmi_meta_q   <= 1'b1;
			nmi_sync_q   <= 1'b1;
			pre_q        <= 7'h0;
			samp_q       <= 3'h7;
			nmi_filtered <= 1'b1;
		end else begin
			nmi_meta_q <= nmi_pin;
			nmi_sync_q <= nmi_meta_q;
			pre_q      <= pre_q + 7'h1;
			if (tick)
				samp_q <= {samp_q[1:0], nmi_sync_q}; // R22
			if (samp_q == 3'h7 || samp_q == 3'h0)
				nmi_filtered <= samp_q[0]; // R22
		end
	end

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	a_ack_one_cycle: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // ack handshake
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack did not follow request for one cycle");

	a_nmi_en_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // R18
		nmi_en_q |=> nmi_en_q)
		else $error("nmi enable was cleared");

	a_od_never_high: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // R13
		((pins_o.out | pins_o.pu) & gpp_pkg::OPEN_DRAIN_MASK) == '0)
		else $error("open-drain pin driven or pulled high");

	a_pullup_input_only: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // R6
		strap_done_q |=> (pins_o.pu & $past(dir_q)) == '0)
		else $error("pull-up on an output pin");

	a_low_pu_exp_off: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // R1
		exp_mode |=> pins_o.pu[47:0] == 48'h0)
		else $error("port 0-5 pull-up active in expansion mode");

	a_dir9_locked: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // R16
		wr && idx == gpp_pkg::DIR_IDX[9] && !unlock_q && !soft_rst |=> $stable(dir_q[9]))
		else $error("port 9 direction changed while locked");

	a_upper_retain: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // R8
		!upper_en && !soft_rst |=> $stable(data_q[13:11]) && $stable(dir_q[13:11]))
		else $error("upper port register changed while disabled");

	a_filter_three: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // R22
		$changed(nmi_filtered) |-> $past(samp_q) == {3{nmi_filtered}})
		else $error("filter passed a level without three equal samples");

	a_soft_pull1: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // R20
		soft_rst && strap_done_q |=> pull1_q == ($past(exp_mode) ?
			gpp_pkg::RST_PULL1_HIGH : gpp_pkg::RST_ZERO))
		else $error("second pull-up register wrong after soft reset");

	a_strap_pull1: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // R19
		!strap_done_q |=> pull1_q == ($past(boot_mode_pin) ?
			gpp_pkg::RST_PULL1_HIGH : gpp_pkg::RST_ZERO))
		else $error("second pull-up register wrong after hard reset");

endmodule

// ===== design/gpp_pkg.sv
// constants, register map and pin carrier for the programmable port bank
package gpp_pkg;

	localparam int NPORT = 15;
	localparam int NPIN  = NPORT * 8;

	// -----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// -----------------------------------------------------------------
	localparam logic [9:0] IDX_PULLUP_CTRL_0 = 10'h360;
	localparam logic [9:0] IDX_PULLUP_CTRL_1 = 10'h361;
	localparam logic [9:0] IDX_PULLUP_CTRL_2 = 10'h362;
	localparam logic [9:0] IDX_PULLUP_CTRL_3 = 10'h363;
	localparam logic [9:0] IDX_PORT_CONTROL  = 10'h366;
	localparam logic [9:0] IDX_NMI_FILTER    = 10'h369;
	localparam logic [9:0] IDX_SYS_CTRL      = 10'h370;
	localparam logic [9:0] DATA_IDX [NPORT] = '{10'h3e0, 10'h3e1, 10'h3e4, 10'h3e5, 10'h3e8,
		10'h3e9, 10'h3ec, 10'h3ed, 10'h3f0, 10'h3f1, 10'h3f4, 10'h3f5, 10'h3f8, 10'h3f9, 10'h3fc};
	localparam logic [9:0] DIR_IDX [NPORT] = '{10'h3e2, 10'h3e3, 10'h3e6, 10'h3e7, 10'h3ea,
		10'h3eb, 10'h3ee, 10'h3ef, 10'h3f2, 10'h3f3, 10'h3f6, 10'h3f7, 10'h3fa, 10'h3fb, 10'h3fe};

	// -----------------------------------------------------------------
	// field positions
	// -----------------------------------------------------------------
	localparam int UPPER_PORTS_ENABLE_BIT   = 7;
	localparam int PORT1_LATCH_READBACK_BIT = 0;
	localparam int SYS_MODE_LSB             = 0;
	localparam int SYS_NMI_EN_BIT           = 2;
	localparam int SYS_SUBCLK_BIT           = 3;
	localparam int SYS_MOTOR_FUNC_BIT       = 4;
	localparam int SYS_MOTOR_OUT_BIT        = 5;
	localparam int SYS_UNLOCK_BIT           = 6;
	localparam int SYS_NMI_LEVEL_BIT        = 7;
	localparam int UPPER_PORT_FIRST         = 11;
	localparam int DIR9_PORT                = 9;

	// -----------------------------------------------------------------
	// reset values and masks
	// -----------------------------------------------------------------
	localparam logic [7:0] RST_ZERO       = 8'h00;
	localparam logic [7:0] RST_PULL1_HIGH = 8'h02;
	localparam logic [7:0] PORT14_MASK    = 8'h03;
	localparam logic [7:0] NMI_FILT_MASK  = 8'h07;
	localparam logic [7:0] PORT_CTL_MASK  = 8'h01;
	localparam logic [1:0] MODE_SINGLE    = 2'h0;
	// pins 56, 57 and 69 are the open-drain ones
	localparam logic [NPIN-1:0] OPEN_DRAIN_MASK = 120'h20_0300_0000_0000_0000;

	// pin drive bundle toward the pads
	typedef struct packed {
		logic [NPIN-1:0] out;
		logic [NPIN-1:0] oe;
		logic [NPIN-1:0] pu;
	} gpp_pins_type;

endpackage

// ===== test/gpp_pin_partner.sv
// external devices on the port pins: drivers, pull-ups and floating lines
`timescale 1ns/100ps
module gpp_pin_partner (
	input  wire logic                  ref_clk,
	input  wire gpp_pkg::gpp_pins_type pins,
	input  wire logic [119:0]          ext_en,
	input  wire logic [119:0]          ext_val,
	output logic      [119:0]          pin_lvl
);
	// an undriven line toggles so a stale level never passes for a real one
	logic [119:0] float_q;

	initial float_q = '0;

	always @(posedge ref_clk) begin
		float_q <= ~float_q;
	end

	always_comb begin
		for (int i = 0; i < 120; i++) begin
			if (pins.oe[i])
				pin_lvl[i] = pins.out[i];
			else if (ext_en[i])
				pin_lvl[i] = ext_val[i];
			else if (pins.pu[i])
				pin_lvl[i] = 1'b1;
			else
				pin_lvl[i] = float_q[i];
		end
	end
endmodule

// ===== test/testbench.sv
// self-checking bench for the programmable port bank
`timescale 1ns/100ps
module testbench;
	logic                  ref_clk;
	logic                  nrst;
	logic                  soft_rst;
	logic                  boot_mode_pin;
	logic                  wb_cyc;
	logic                  wb_stb;
	logic                  wb_we;
	logic [11:0]           wb_adr;
	logic [3:0]            wb_sel;
	logic [31:0]           wb_dat;
	logic [31:0]           wb_dat_o;
	logic                  wb_ack_o;
	logic [119:0]          pin_lvl;
	logic [119:0]          bus_pin_mask;
	logic [119:0]          ext_en;
	logic [119:0]          ext_val;
	logic                  nmi_pin;
	logic                  nmi_filtered;
	gpp_pkg::gpp_pins_type pins;
	logic [7:0]            rq;
	int                    failures;
	int                    cmp_count;

	gpp_port_bank uut (.ref_clk(ref_clk), .nrst(nrst), .soft_rst(soft_rst),
		.boot_mode_pin(boot_mode_pin), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_in(pin_lvl),
		.bus_pin_mask(bus_pin_mask), .nmi_pin(nmi_pin), .pins_o(pins),
		.nmi_filtered(nmi_filtered));

	gpp_pin_partner far (.ref_clk(ref_clk), .pins(pins), .ext_en(ext_en),
		.ext_val(ext_val), .pin_lvl(pin_lvl));

	initial ref_clk = 1'b0;
	always #25 ref_clk = ~ref_clk;

	// -----------------------------------------------------------------
	// bus and compare helpers
	// -----------------------------------------------------------------
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// the request is held until ack is sampled; no latency is assumed
	task automatic bus(input logic we, input logic [9:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we  <= we;
		wb_adr <= {idx, 2'b00};
		wb_sel <= 4'h1;
		wb_dat <= {24'h0, d};
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20) begin
			failures++;
			$display("wrong value ack expected 1 seen 0");
		end
		rq = wb_dat_o[7:0];
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d);
	endtask

	task automatic rd(input string nm, input logic [9:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h00);
		chk(nm, {8'h00, exp}, {8'h00, rq});
	endtask

	task automatic stop_test;
		if (failures == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// -----------------------------------------------------------------
	// scenarios
	// -----------------------------------------------------------------
	task automatic t_reset;
		rd("dir0", gpp_pkg::DIR_IDX[0], 8'h00);
		rd("dir13", gpp_pkg::DIR_IDX[13], 8'h00);
		rd("pull ctrl 1", gpp_pkg::IDX_PULLUP_CTRL_1, 8'h00);
		rd("unmapped", 10'h100, 8'h00);
		wr(gpp_pkg::IDX_NMI_FILTER, 8'hfd);
		rd("filter select", gpp_pkg::IDX_NMI_FILTER, 8'h05);
	endtask

	task automatic t_output;
		wr(gpp_pkg::DIR_IDX[0], 8'hff);
		wr(gpp_pkg::DATA_IDX[0], 8'ha5);
		chk("out0", 16'h00a5, {8'h00, pins.out[7:0]});
		chk("oe0", 16'h00ff, {8'h00, pins.oe[7:0]});
		rd("data0 out", gpp_pkg::DATA_IDX[0], 8'ha5);
		wr(gpp_pkg::DIR_IDX[0], 8'h00);
		ext_en[7:0] <= 8'hff;
		ext_val[7:0] <= 8'h3c;
		wr(gpp_pkg::DATA_IDX[0], 8'h11);
		rd("data0 in", gpp_pkg::DATA_IDX[0], 8'h3c);
		ext_en[7:0] <= 8'h00;
		wr(gpp_pkg::DIR_IDX[0], 8'hff);
		chk("out0 latch", 16'h0011, {8'h00, pins.out[7:0]});
	endtask

	task automatic t_pullups;
		wr(gpp_pkg::IDX_PULLUP_CTRL_0, 8'h03);
		wr(gpp_pkg::DIR_IDX[0], 8'hf0);
		chk("pu0", 16'h000f, {8'h00, pins.pu[7:0]});
		wr(gpp_pkg::IDX_PULLUP_CTRL_1, 8'h40);
		wr(gpp_pkg::IDX_PULLUP_CTRL_2, 8'h02);
		chk("pu7 pu8", 16'hd00c, pins.pu[71:56]);
		wr(gpp_pkg::DATA_IDX[7], 8'h01);
		wr(gpp_pkg::DIR_IDX[7], 8'h01);
		chk("od float", 16'h0000, {15'h0, pins.oe[56]});
		wr(gpp_pkg::DATA_IDX[7], 8'h00);
		chk("od low", 16'h0002, {14'h0, pins.oe[56], pins.out[56]});
	endtask

	task automatic t_readback;
		ext_en[15:8] <= 8'hff;
		ext_val[15:8] <= 8'h0f;
		wr(gpp_pkg::DATA_IDX[1], 8'hf0);
		rd("data1 pin", gpp_pkg::DATA_IDX[1], 8'h0f);
		wr(gpp_pkg::IDX_PORT_CONTROL, 8'h01);
		rd("data1 latch", gpp_pkg::DATA_IDX[1], 8'hf0);
		ext_val[71:64] <= 8'hff;
		ext_en[71:64] <= 8'hff;
		wr(gpp_pkg::IDX_SYS_CTRL, 8'h08);
		rd("data8 subclock", gpp_pkg::DATA_IDX[8], 8'h3f);
		wr(gpp_pkg::IDX_SYS_CTRL, 8'h00);
		ext_en[71:8] <= 64'h0;
	endtask

	task automatic t_upper;
		wr(gpp_pkg::DATA_IDX[11], 8'h77);
		rd("port11 off", gpp_pkg::DATA_IDX[11], 8'h00);
		wr(gpp_pkg::IDX_PULLUP_CTRL_3, 8'h80);
		wr(gpp_pkg::DATA_IDX[11], 8'h77);
		wr(gpp_pkg::DIR_IDX[11], 8'hff);
		chk("out11", 16'h0077, {8'h00, pins.out[95:88]});
		wr(gpp_pkg::IDX_PULLUP_CTRL_3, 8'h00);
		rd("port11 hidden", gpp_pkg::DATA_IDX[11], 8'h00);
		wr(gpp_pkg::IDX_PULLUP_CTRL_3, 8'h80);
		rd("port11 kept", gpp_pkg::DATA_IDX[11], 8'h77);
	endtask

	task automatic t_unlock;
		wr(gpp_pkg::DIR_IDX[9], 8'h5a);
		rd("dir9 locked", gpp_pkg::DIR_IDX[9], 8'h00);
		wr(gpp_pkg::IDX_SYS_CTRL, 8'h40);
		wr(gpp_pkg::DIR_IDX[9], 8'h5a);
		rd("dir9 open", gpp_pkg::DIR_IDX[9], 8'h5a);
		wr(gpp_pkg::IDX_SYS_CTRL, 8'h40);
		wr(gpp_pkg::DATA_IDX[9], 8'h00);
		wr(gpp_pkg::DIR_IDX[9], 8'hff);
		rd("dir9 relock", gpp_pkg::DIR_IDX[9], 8'h5a);
	endtask

	task automatic t_nmi_enable;
		wr(gpp_pkg::IDX_SYS_CTRL, 8'h04);
		wr(gpp_pkg::IDX_SYS_CTRL, 8'h00);
		bus(1'b0, gpp_pkg::IDX_SYS_CTRL, 8'h00);
		chk("nmi enable", 16'h0001, {15'h0, rq[2]});
	endtask

	task automatic t_expansion;
		bus_pin_mask[7:0] <= 8'hff;
		wr(gpp_pkg::IDX_SYS_CTRL, 8'h05);
		wr(gpp_pkg::DIR_IDX[0], 8'h0f);
		rd("dir0 bus pin", gpp_pkg::DIR_IDX[0], 8'hf0);
		wr(gpp_pkg::IDX_PULLUP_CTRL_1, 8'h01);
		chk("pu0 pu4", 16'h0000, {4'h0, pins.pu[35:32], pins.pu[7:0]});
		soft_rst <= 1'b1;
		@(posedge ref_clk);
		soft_rst <= 1'b0;
		@(posedge ref_clk);
		rd("pull ctrl 1 soft", gpp_pkg::IDX_PULLUP_CTRL_1, 8'h02);
		rd("filter soft", gpp_pkg::IDX_NMI_FILTER, 8'h00);
		rd("dir7 soft", gpp_pkg::DIR_IDX[7], 8'h00);
		wr(gpp_pkg::IDX_SYS_CTRL, 8'h04);
		bus_pin_mask[7:0] <= 8'h00;
	endtask

	// second hard reset with the boot strap high
	task automatic t_boot_strap;
		boot_mode_pin <= 1'b1;
		nrst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rd("pull ctrl 1 strap", gpp_pkg::IDX_PULLUP_CTRL_1, 8'h02);
		rd("filter hard", gpp_pkg::IDX_NMI_FILTER, 8'h00);
		boot_mode_pin <= 1'b0;
	endtask

	task automatic t_filter;
		nmi_pin <= 1'b0;
		repeat (2) @(posedge ref_clk);
		nmi_pin <= 1'b1;
		repeat (6) @(posedge ref_clk);
		chk("nmi glitch", 16'h0001, {15'h0, nmi_filtered});
		nmi_pin <= 1'b0;
		repeat (8) @(posedge ref_clk);
		chk("nmi low", 16'h0000, {15'h0, nmi_filtered});
		nmi_pin <= 1'b1;
	endtask

	initial begin
		repeat (5000) @(posedge ref_clk);
		failures++;
		stop_test();
	end

	initial begin
		failures = 0;
		cmp_count = 0;
		nrst = 1'b0;
		soft_rst = 1'b0;
		boot_mode_pin = 1'b0;
		{wb_cyc, wb_stb, wb_we} = 3'h0;
		wb_adr = 12'h000;
		wb_sel = 4'h0;
		wb_dat = 32'h0;
		bus_pin_mask = '0;
		ext_en = '0;
		ext_val = '0;
		nmi_pin = 1'b1;
		repeat (16) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (4) @(posedge ref_clk);
		t_reset();
		t_output();
		t_pullups();
		t_readback();
		t_upper();
		t_unlock();
		t_nmi_enable();
		t_expansion();
		t_boot_strap();
		t_filter();
		stop_test();
	end
endmodule
